/* include/pin_mux_pkg.sv */
// Package of constants for the multifunction pin multiplexer.
`default_nettype none
package pin_mux_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_GP_FUNC = 8'h00;
    localparam logic [7:0] ADDR_GP_OUT = 8'h04;
    localparam logic [7:0] ADDR_GP_OE = 8'h08;
    localparam logic [7:0] ADDR_FAST_FUNC = 8'h0C;
    localparam logic [7:0] ADDR_FAST_OUT = 8'h10;
    localparam logic [7:0] ADDR_FAST_OE = 8'h14;
    localparam logic [7:0] ADDR_LOC_FUNC = 8'h18;
    localparam logic [7:0] ADDR_LOC_OUT = 8'h1C;
    localparam logic [7:0] ADDR_LOC_OE = 8'h20;
    localparam logic [7:0] ADDR_PIN_IN = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [3:0] FUNC_RST = 4'h0;
    localparam logic [3:0] OUT_RST = 4'h0;
    localparam logic [3:0] GP_OE_RST = 4'hF;
    localparam logic [3:0] FAST_OE_RST = 4'h0;
    localparam logic [3:0] LOC_OE_RST = 4'hF;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam int IN_GP_LSB = 0;
    localparam int IN_FAST_LSB = 4;
    localparam int IN_LOC_LSB = 8;
    localparam int ST_DUAL_BIT = 0;
    localparam int ST_LOCAL_BIT = 1;
endpackage
`default_nettype wire

/* src/pin_mux.sv */
// Pin function multiplexer for the general purpose and shared pins.
//
// Behaviour
// RULE1: Standard pins reset to GPIO driving low.
// RULE2: Fast pins reset to GPIO, tri-stated.
// RULE3: Fast pins work only in dual-lane mode.
// RULE4: Pins 5-8 local-only, reset driving low.
// RULE5: One function per pin, register selected.
// RULE6: Software disables jitter cleaner before bit clock.
// RULE7: Pins 5-8 carry slave audio outputs.
// RULE8: Fast pins share MOSI, MISO, SCLK, select.
// RULE9: Selects return to GPIO on power-up.
//
// The address map and strobed register access were decided locally.
`default_nettype none
module pin_mux (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Device state
    input wire logic i_dual_link,
    input wire logic i_local_access,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Alternate function sources
    input wire logic [3:0] i_gp_alt,
    input wire logic i_spi_mosi,
    input wire logic i_spi_miso,
    input wire logic i_spi_sclk,
    input wire logic i_spi_ss,
    input wire logic i_spi_master,
    input wire logic i_audio_lane_a,
    input wire logic i_audio_lane_b,
    input wire logic i_audio_word_clk,
    input wire logic i_audio_bit_clk,
    // Standard pins 1, 2, 3, 9
    input wire logic [3:0] i_gp_pin,
    output logic [3:0] o_gp_pin,
    output logic [3:0] o_gp_pin_oe,
    // Fast pins 0 to 3
    input wire logic [3:0] i_fast_pin,
    output logic [3:0] o_fast_pin,
    output logic [3:0] o_fast_pin_oe,
    // Local-only pins 5 to 8
    input wire logic [3:0] i_local_only_pin,
    output logic [3:0] o_local_only_pin,
    output logic [3:0] o_local_only_pin_oe,
    // Received spi lines
    output logic o_spi_mosi_in,
    output logic o_spi_miso_in,
    output logic o_spi_sclk_in,
    output logic o_spi_ss_in
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [3:0] gp_func, gp_out, gp_oe;
    logic [3:0] fast_func, fast_out, fast_oe;
    logic [3:0] loc_func, loc_out, loc_oe;
    logic [3:0] next_gp_func, next_gp_out, next_gp_oe;
    logic [3:0] next_fast_func, next_fast_out, next_fast_oe;
    logic [3:0] next_loc_func, next_loc_out, next_loc_oe;
    logic [31:0] rdata, next_rdata;
    logic loc_wr;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Local-only pins refuse writes that arrive over the link.
    assign loc_wr = i_wr && i_local_access; // [RULE4]

    always_comb begin
        next_gp_func = gp_func;
        next_gp_out = gp_out;
        next_gp_oe = gp_oe;
        next_fast_func = fast_func;
        next_fast_out = fast_out;
        next_fast_oe = fast_oe;
        next_loc_func = loc_func;
        next_loc_out = loc_out;
        next_loc_oe = loc_oe;
        next_rdata = pin_mux_pkg::READ_ZERO;
        if (i_wr) begin
            if (hit(i_addr, pin_mux_pkg::ADDR_GP_FUNC)) begin
                next_gp_func = i_wdata[3:0]; // [RULE5]
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_GP_OUT)) begin
                next_gp_out = i_wdata[3:0];
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_GP_OE)) begin
                next_gp_oe = i_wdata[3:0];
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_FAST_FUNC)) begin
                next_fast_func = i_wdata[3:0];
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_FAST_OUT)) begin
                next_fast_out = i_wdata[3:0];
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_FAST_OE)) begin
                next_fast_oe = i_wdata[3:0];
            end
        end
        if (loc_wr) begin
            if (hit(i_addr, pin_mux_pkg::ADDR_LOC_FUNC)) begin
                next_loc_func = i_wdata[3:0]; // [RULE4]
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_LOC_OUT)) begin
                next_loc_out = i_wdata[3:0];
            end
            if (hit(i_addr, pin_mux_pkg::ADDR_LOC_OE)) begin
                next_loc_oe = i_wdata[3:0];
            end
        end
        if (i_rd) begin
            case (i_addr)
                pin_mux_pkg::ADDR_GP_FUNC: next_rdata[3:0] = gp_func;
                pin_mux_pkg::ADDR_GP_OUT: next_rdata[3:0] = gp_out;
                pin_mux_pkg::ADDR_GP_OE: next_rdata[3:0] = gp_oe;
                pin_mux_pkg::ADDR_FAST_FUNC: next_rdata[3:0] = fast_func;
                pin_mux_pkg::ADDR_FAST_OUT: next_rdata[3:0] = fast_out;
                pin_mux_pkg::ADDR_FAST_OE: next_rdata[3:0] = fast_oe;
                pin_mux_pkg::ADDR_LOC_FUNC: next_rdata[3:0] = loc_func;
                pin_mux_pkg::ADDR_LOC_OUT: next_rdata[3:0] = loc_out;
                pin_mux_pkg::ADDR_LOC_OE: next_rdata[3:0] = loc_oe;
                pin_mux_pkg::ADDR_PIN_IN: begin
                    next_rdata[pin_mux_pkg::IN_GP_LSB +: 4] = i_gp_pin;
                    next_rdata[pin_mux_pkg::IN_FAST_LSB +: 4] = i_fast_pin;
                    next_rdata[pin_mux_pkg::IN_LOC_LSB +: 4] =
                        i_local_only_pin;
                end
                pin_mux_pkg::ADDR_STATUS: begin
                    next_rdata[pin_mux_pkg::ST_DUAL_BIT] = i_dual_link;
                    next_rdata[pin_mux_pkg::ST_LOCAL_BIT] = i_local_access;
                end
                default: next_rdata = pin_mux_pkg::READ_ZERO;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Power-down drives this reset, so leaving it restores every default.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            gp_func <= pin_mux_pkg::FUNC_RST; // [RULE9]
            gp_out <= pin_mux_pkg::OUT_RST; // [RULE1]
            gp_oe <= pin_mux_pkg::GP_OE_RST; // [RULE1]
            fast_func <= pin_mux_pkg::FUNC_RST; // [RULE9]
            fast_out <= pin_mux_pkg::OUT_RST;
            fast_oe <= pin_mux_pkg::FAST_OE_RST; // [RULE2]
            loc_func <= pin_mux_pkg::FUNC_RST; // [RULE9]
            loc_out <= pin_mux_pkg::OUT_RST; // [RULE4]
            loc_oe <= pin_mux_pkg::LOC_OE_RST; // [RULE4]
            rdata <= pin_mux_pkg::READ_ZERO;
        end else begin
            gp_func <= next_gp_func;
            gp_out <= next_gp_out;
            gp_oe <= next_gp_oe;
            fast_func <= next_fast_func;
            fast_out <= next_fast_out;
            fast_oe <= next_fast_oe;
            loc_func <= next_loc_func;
            loc_out <= next_loc_out;
            loc_oe <= next_loc_oe;
            rdata <= next_rdata;
        end
    end

    assign o_rdata = rdata;

    // ----------------------------------------------------------------
    // Pin steering
    // ----------------------------------------------------------------
    logic [3:0] spi_val, spi_drv, audio_val;
    // MOSI and clock and select leave a master; MISO leaves a slave.
    assign spi_val = {i_spi_ss, i_spi_sclk, i_spi_miso, i_spi_mosi}; // [RULE8]
    assign spi_drv = {i_spi_master, i_spi_master, !i_spi_master,
                      i_spi_master}; // [RULE8]
    assign audio_val = {i_audio_bit_clk, i_audio_word_clk, i_audio_lane_a,
                        i_audio_lane_b}; // [RULE7]

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            // Exactly one source per pin: the select picks it.
            o_gp_pin[k] = gp_func[k] ? i_gp_alt[k] : gp_out[k]; // [RULE5]
            o_gp_pin_oe[k] = gp_func[k] ? 1'b1 : gp_oe[k]; // [RULE5]
        end
    end

    // The bit clock is only clean once software has turned the audio
    // jitter cleaner off; this block cannot see that setting.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (loc_func[k]) begin
                o_local_only_pin[k] = audio_val[k]; // [RULE7]
                o_local_only_pin_oe[k] = 1'b1; // [RULE7]
            end else begin
                o_local_only_pin[k] = loc_out[k]; // [RULE4]
                o_local_only_pin_oe[k] = loc_oe[k]; // [RULE4]
            end
        end
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (!i_dual_link) begin
                o_fast_pin[k] = 1'b0; // [RULE3]
                o_fast_pin_oe[k] = 1'b0; // [RULE3]
            end else if (fast_func[k]) begin
                o_fast_pin[k] = spi_val[k]; // [RULE8]
                o_fast_pin_oe[k] = spi_drv[k]; // [RULE8]
            end else begin
                o_fast_pin[k] = fast_out[k];
                o_fast_pin_oe[k] = fast_oe[k]; // [RULE2]
            end
        end
    end

    // ----------------------------------------------------------------
    // Spi receive
    // ----------------------------------------------------------------
    // Receive side of the spi lines, only in dual-lane alternate mode.
    logic [3:0] spi_in;
    assign spi_in = (i_dual_link ? fast_func : 4'h0) & i_fast_pin; // [RULE3]
    assign o_spi_mosi_in = spi_in[0];
    assign o_spi_miso_in = spi_in[1];
    assign o_spi_sclk_in = spi_in[2];
    assign o_spi_ss_in = spi_in[3];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_single_lane_off: assert property ( // [RULE3]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !i_dual_link |-> o_fast_pin_oe == 4'h0)
        else $error("fast pin driven in single lane");
    a_single_lane_rx: assert property ( // [RULE3]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !i_dual_link |-> {o_spi_ss_in, o_spi_sclk_in, o_spi_miso_in,
            o_spi_mosi_in} == 4'h0)
        else $error("spi input passed in single lane");
    a_reset_gp_low: assert property ( // [RULE1]
        @(posedge i_ref_clk)
        $rose(i_rstn) |-> o_gp_pin == 4'h0 && o_gp_pin_oe == 4'hF)
        else $error("gp pin not low after reset");
    a_reset_fast_tri: assert property ( // [RULE2]
        @(posedge i_ref_clk)
        $rose(i_rstn) |-> o_fast_pin_oe == 4'h0)
        else $error("fast pin not tri-state after reset");
    a_reset_loc_low: assert property ( // [RULE4]
        @(posedge i_ref_clk)
        $rose(i_rstn) |-> o_local_only_pin == 4'h0
            && o_local_only_pin_oe == 4'hF)
        else $error("local pin not low after reset");
    a_remote_loc_blocked: assert property ( // [RULE4]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_wr && !i_local_access |=> $stable(loc_func) && $stable(loc_out))
        else $error("remote write reached local pin");
    a_remote_oe_blocked: assert property ( // [RULE4]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_wr && !i_local_access |=> $stable(loc_oe))
        else $error("remote write reached local enable");
    a_audio_select: assert property ( // [RULE7]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        loc_func[3] |-> o_local_only_pin[3] == i_audio_bit_clk)
        else $error("bit clock not on pin 8");
    a_audio_word_clk: assert property ( // [RULE7]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        loc_func[2] |-> o_local_only_pin[2] == i_audio_word_clk)
        else $error("word clock not on pin 7");
    a_audio_lane_a: assert property ( // [RULE7]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        loc_func[1] |-> o_local_only_pin[1] == i_audio_lane_a)
        else $error("lane a not on pin 6");
    a_audio_lane_b: assert property ( // [RULE7]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        loc_func[0] |-> o_local_only_pin[0] == i_audio_lane_b)
        else $error("lane b not on pin 5");
    a_func_exclusive: assert property ( // [RULE5]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !gp_func[0] |-> o_gp_pin[0] == gp_out[0])
        else $error("alternate leaked onto gpio pin");
    a_alt_on_gp: assert property ( // [RULE5]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        gp_func[0] |-> o_gp_pin[0] == i_gp_alt[0])
        else $error("alternate missing on gpio pin");
    a_alt_gp_drive: assert property ( // [RULE5]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (o_gp_pin_oe & gp_func) == gp_func)
        else $error("alternate pin not driven");
    a_func_default: assert property ( // [RULE9]
        @(posedge i_ref_clk)
        !i_rstn |=> gp_func == 4'h0 && fast_func == 4'h0 && loc_func == 4'h0)
        else $error("select not restored");
    a_spi_order: assert property ( // [RULE8]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_dual_link && fast_func[2] |-> o_fast_pin[2] == i_spi_sclk)
        else $error("spi clock not on fast pin 2");
    a_spi_mosi_pin: assert property ( // [RULE8]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_dual_link && fast_func[0] |-> o_fast_pin[0] == i_spi_mosi)
        else $error("mosi not on fast pin 0");
    a_spi_miso_pin: assert property ( // [RULE8]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_dual_link && fast_func[1] |-> o_fast_pin[1] == i_spi_miso)
        else $error("miso not on fast pin 1");
    a_spi_select_pin: assert property ( // [RULE8]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_dual_link && fast_func[3] |-> o_fast_pin[3] == i_spi_ss)
        else $error("select not on fast pin 3");
endmodule
`default_nettype wire

/* verification/board_pins.sv */
// Board-side model of the shared pads with pull-downs and drivers.
`default_nettype none
module board_pins (
    // Device side of each pad
    input wire logic [11:0] i_dev_out,
    input wire logic [11:0] i_dev_oe,
    // External board drivers
    input wire logic [11:0] i_ext_val,
    input wire logic [11:0] i_ext_en,
    // Resolved pad levels
    output logic [11:0] o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pad falls to its weak pull-down, so a stale drive
    // cannot pass for a live one; two drivers at once give unknown.
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (i_dev_oe[i] && i_ext_en[i]) begin
                o_level[i] = 1'bx;
            end else if (i_dev_oe[i]) begin
                o_level[i] = i_dev_out[i];
            end else begin
                o_level[i] = i_ext_en[i] ? i_ext_val[i] : 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the pin function multiplexer.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic dual = 1'b1;
    logic local_acc = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [3:0] gp_alt = 4'h0;
    logic [3:0] spi = 4'h0;
    logic [3:0] aud = 4'h0;
    logic spi_master = 1'b1;
    logic [11:0] ext_val = 12'h000;
    logic [11:0] ext_en = 12'h000;
    logic [31:0] o_rdata;
    logic [3:0] gp, gp_oe, fast, fast_oe, loc, loc_oe, spi_in;
    logic [11:0] level;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] raddr [10] = '{pin_mux_pkg::ADDR_GP_FUNC,
        pin_mux_pkg::ADDR_GP_OUT, pin_mux_pkg::ADDR_GP_OE,
        pin_mux_pkg::ADDR_FAST_FUNC, pin_mux_pkg::ADDR_FAST_OUT,
        pin_mux_pkg::ADDR_FAST_OE, pin_mux_pkg::ADDR_LOC_FUNC,
        pin_mux_pkg::ADDR_LOC_OUT, pin_mux_pkg::ADDR_LOC_OE, 8'h40};
    logic [3:0] rexp [10] = '{pin_mux_pkg::FUNC_RST, pin_mux_pkg::OUT_RST,
        pin_mux_pkg::GP_OE_RST, pin_mux_pkg::FUNC_RST, pin_mux_pkg::OUT_RST,
        pin_mux_pkg::FAST_OE_RST, pin_mux_pkg::FUNC_RST,
        pin_mux_pkg::OUT_RST, pin_mux_pkg::LOC_OE_RST, 4'h0};

    always #4 i_ref_clk = ~i_ref_clk;

    board_pins i_board (.i_dev_out({loc, fast, gp}),
        .i_dev_oe({loc_oe, fast_oe, gp_oe}), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_level(level));

    pin_mux i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_dual_link(dual), .i_local_access(local_acc), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(o_rdata),
        .i_gp_alt(gp_alt), .i_spi_mosi(spi[0]), .i_spi_miso(spi[1]),
        .i_spi_sclk(spi[2]), .i_spi_ss(spi[3]), .i_spi_master(spi_master),
        .i_audio_lane_b(aud[0]), .i_audio_lane_a(aud[1]),
        .i_audio_word_clk(aud[2]), .i_audio_bit_clk(aud[3]),
        .i_gp_pin(level[3:0]), .o_gp_pin(gp), .o_gp_pin_oe(gp_oe),
        .i_fast_pin(level[7:4]), .o_fast_pin(fast), .o_fast_pin_oe(fast_oe),
        .i_local_only_pin(level[11:8]), .o_local_only_pin(loc),
        .o_local_only_pin_oe(loc_oe), .o_spi_mosi_in(spi_in[0]),
        .o_spi_miso_in(spi_in[1]), .o_spi_sclk_in(spi_in[2]),
        .o_spi_ss_in(spi_in[3]));

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_ref_clk);
        wr_s <= 1'b0;
        #1;
    endtask

    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        @(posedge i_ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge i_ref_clk);
        rd_s <= 1'b0;
        #1;
        check(what, exp, o_rdata);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        #1;
        check("gp pins", 32'h0, 32'(gp));
        check("gp oe", 32'hF, 32'(gp_oe));
        check("fast oe", 32'h0, 32'(fast_oe));
        check("local pins", 32'h0, 32'(loc));
        for (int i = 0; i < 10; i++) begin
            rchk("reg", raddr[i], 32'(rexp[i]));
        end
        rchk("status", pin_mux_pkg::ADDR_STATUS, 32'h3);
        $display("test reset done");
        @(posedge i_ref_clk) gp_alt <= 4'hF;
        wr(pin_mux_pkg::ADDR_GP_FUNC, 32'h5);
        check("gp mixed", 32'h5, 32'(gp));
        @(posedge i_ref_clk) gp_alt <= 4'hA;
        #1 check("gp alt", 32'h0, 32'(gp));
        wr(pin_mux_pkg::ADDR_GP_OUT, 32'hF);
        check("gp out", 32'hA, 32'(gp));
        $display("test gp done");
        @(posedge i_ref_clk) local_acc <= 1'b0;
        wr(pin_mux_pkg::ADDR_LOC_OUT, 32'hF);
        check("remote out", 32'h0, 32'(loc));
        @(posedge i_ref_clk) local_acc <= 1'b1;
        wr(8'h2B, 32'h80);
        rchk("outside reg", 8'h2B, 32'h0);
        wr(pin_mux_pkg::ADDR_LOC_FUNC, 32'hF);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_ref_clk) aud <= k ? 4'h9 : 4'h6;
            #1 check("audio", k ? 32'h9 : 32'h6, 32'(loc));
        end
        $display("test local done");
        wr(pin_mux_pkg::ADDR_FAST_OE, 32'hF);
        wr(pin_mux_pkg::ADDR_FAST_OUT, 32'hA);
        check("fast dual", 32'hA, 32'(fast));
        @(posedge i_ref_clk) dual <= 1'b0;
        #1 check("fast single", 32'h0, 32'(fast_oe));
        rchk("status", pin_mux_pkg::ADDR_STATUS, 32'h2);
        wr(pin_mux_pkg::ADDR_FAST_OE, 32'h0);
        wr(pin_mux_pkg::ADDR_FAST_FUNC, 32'hF);
        @(posedge i_ref_clk) ext_en[5] <= 1'b1;
        ext_val[5] <= 1'b1;
        #1 check("miso single", 32'h0, 32'(spi_in[1]));
        @(posedge i_ref_clk) dual <= 1'b1;
        spi <= 4'b1101;
        #1 check("spi out", 32'hD, 32'(fast & 4'hD));
        check("spi oe", 32'hD, 32'(fast_oe));
        check("miso in", 32'h1, 32'(spi_in[1]));
        check("spi in", 32'hF, 32'(spi_in));
        rchk("pin in", pin_mux_pkg::ADDR_PIN_IN, 32'h0000_09FA);
        @(posedge i_ref_clk) spi_master <= 1'b0;
        ext_en[5] <= 1'b0;
        #1 check("spi slave oe", 32'h2, 32'(fast_oe));
        $display("test fast done");
        @(posedge i_ref_clk) i_rstn <= 1'b0;
        ext_en <= 12'h000;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rchk("rereg", raddr[i], 32'(rexp[i]));
        end
        $display("test rerun done");
        stop_test();
    end
endmodule
`default_nettype wire
